// [core/dqs_pkg.sv]
// package of constants and types for the dual-quad lane front end and reset
//
// Operation
// - instruction bits only on lanes 0 and 4
// - address nibbles on lanes 0-3, copied 4-7
// - write and read data as whole bytes
// - one shared select and one shared clock
// - long reset low aborts work, tristates outputs
// - reset restores volatile config and status bits
// - reset clears the bank address register
// - reset fills page buffer with ones
// - reset reloads config, sequencer returns to standby
// - reset reruns power-up init, commands wait
// - absent reset pin behaves as deasserted
// - every command starts with eight-bit instruction
// - capture on rising edge, drive after falling
// - select high ignores inputs, outputs tristated
package dqs_pkg;

	// ----------------------------------------------------------------
	// bus shape
	// ----------------------------------------------------------------
	localparam int          LANES         = 8;
	localparam int          NIB_W         = 4;
	localparam int          INSTR_BITS    = 8;
	localparam int          LANE_INSTR_A  = 0;
	localparam int          LANE_INSTR_B  = 4;
	localparam int          CNT_W         = 8;
	localparam int          RST_CNT_W     = 16;
	localparam int          PU_CNT_W      = 32;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          CLK_PERIOD_NS = 10;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  CFG_VOL_RST   = 8'h00;
	localparam logic [7:0]  STS_VOL_RST   = 8'h00;
	localparam logic [7:0]  BANK_RST      = 8'h00;
	localparam logic [7:0]  PBUF_FILL     = 8'hFF;
	localparam logic [7:0]  LANES_OFF     = 8'h00;
	localparam logic [7:0]  LANES_ON      = 8'hFF;

	// sequencer states
	typedef enum logic [2:0] {
		ST_INIT,
		ST_IDLE,
		ST_INSTR,
		ST_ADDR,
		ST_DUMMY,
		ST_RDATA,
		ST_WDATA,
		ST_IGNORE
	} dqs_state_t;

	// least time in ns to whole clock cycles, never below one
	function automatic int dqs_cyc_ceil(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : dqs_cyc_ceil

endpackage : dqs_pkg

// [core/dqs_pin_sync.sv]
// two-flop synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module dqs_pin_sync #(
	parameter int          W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_ce,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_reg;
	logic [W-1:0] q_next;

	// first stage feeds only the second
	always_comb
	begin
		meta_next = i_d;
		q_next    = meta_reg;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			meta_reg <= RST_VAL;
			q_reg    <= RST_VAL;
		end
		else if (i_ce)
		begin
			meta_reg <= meta_next;
			q_reg    <= q_next;
		end
	end

	assign o_q = q_reg;

endmodule : dqs_pin_sync

// [core/dqs_lanes_reset.sv]
// dual-quad lane front end with hardware reset sequencing
`timescale 1ns/1ps
module dqs_lanes_reset #(
	parameter int          ADDR_NIBBLES = 8,
	parameter int          DUMMY_CYCLES = 0,
	parameter int          PAGE_BYTES   = 512,
	parameter int          T_RP_NS      = 200,
	parameter int          T_PU_NS      = 300000,
	parameter int          PU_CYC       = dqs_pkg::dqs_cyc_ceil(T_PU_NS),
	parameter bit          HAS_RESET_PIN = 1'b1,
	parameter logic [7:0]  OP_READ      = 8'hA5,
	parameter logic [7:0]  OP_WRITE     = 8'h5A
) (
	input  wire logic                           i_clk,
	input  wire logic                           i_rst,
	input  wire logic                           i_ce,
	input  wire logic                           i_sck,
	input  wire logic                           i_cs_n,
	input  wire logic                           i_reset_n,
	input  wire logic [dqs_pkg::LANES-1:0]      i_bidir_lanes,
	output logic      [dqs_pkg::LANES-1:0]      o_bidir_lanes,
	output logic      [dqs_pkg::LANES-1:0]      o_bidir_lanes_oe,
	input  wire logic                           i_cfg_we,
	input  wire logic [7:0]                     i_cfg_wdata,
	input  wire logic                           i_sts_we,
	input  wire logic [7:0]                     i_sts_wdata,
	input  wire logic                           i_bank_we,
	input  wire logic [7:0]                     i_bank_wdata,
	input  wire logic [$clog2(PAGE_BYTES)-1:0]  i_pbuf_raddr,
	output logic      [7:0]                     o_pbuf_rdata,
	output logic      [7:0]                     o_cfg_vol,
	output logic      [7:0]                     o_sts_vol,
	output logic      [7:0]                     o_bank,
	output logic      [dqs_pkg::INSTR_BITS-1:0] o_instr,
	output logic                                o_instr_valid,
	output logic                                o_mirror_err,
	output logic                                o_ready
);
	import dqs_pkg::*;

	localparam int PB_AW  = $clog2(PAGE_BYTES);
	localparam int ADDR_W = ADDR_NIBBLES * NIB_W;
	localparam int RP_CYC = dqs_cyc_ceil(T_RP_NS);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic             s_sck;
	logic             s_cs_n;
	logic             s_rst_n;
	logic [LANES-1:0] s_lanes;

	// select and clock are one pin each, shared by both quad units
	// reset to idle levels: select high, reset pin high, clock low, so no false edge
	dqs_pin_sync #(.W(3), .RST_VAL(3'h6)) u_sync_ctl (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_ce  (i_ce),
		.i_d   ({i_cs_n, i_reset_n, i_sck}),
		.o_q   ({s_cs_n, s_rst_n, s_sck})
	);

	dqs_pin_sync #(.W(LANES), .RST_VAL(LANES_OFF)) u_sync_lanes (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_ce  (i_ce),
		.i_d   (i_bidir_lanes),
		.o_q   (s_lanes)
	);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	dqs_state_t           state_reg,    state_next;
	logic                 sck_d_reg,    sck_d_next;
	logic                 cs_d_reg,     cs_d_next;
	logic [CNT_W-1:0]     cnt_reg,      cnt_next;
	logic [ADDR_W-1:0]    addr_reg,     addr_next;
	logic [PB_AW-1:0]     idx_reg,      idx_next;
	logic [PB_AW:0]       fill_reg,     fill_next;
	logic [RST_CNT_W-1:0] rcnt_reg,     rcnt_next;
	logic [PU_CNT_W-1:0]  pu_reg,       pu_next;
	logic [7:0]           lanes_reg,    lanes_next;
	logic [7:0]           oe_reg,       oe_next;
	logic [7:0]           instr_reg,    instr_next;
	logic                 ivalid_reg,   ivalid_next;
	logic                 merr_reg,     merr_next;
	logic                 ready_reg,    ready_next;
	logic [7:0]           cfg_reg,      cfg_next;
	logic [7:0]           sts_reg,      sts_next;
	logic [7:0]           bank_reg,     bank_next;
	logic [7:0]           prd_reg,      prd_next;
	logic [7:0]           pbuf [PAGE_BYTES];
	logic                 pb_we;
	logic [PB_AW-1:0]     pb_wa;
	logic [7:0]           pb_wd;

	logic pin_low;
	logic rise;
	logic fall;
	logic cs_fall;
	logic hw_reset;
	logic [7:0] instr_new;
	logic [ADDR_W-1:0] addr_new;

	// absent pin reads as deasserted
	assign pin_low  = HAS_RESET_PIN ? ~s_rst_n : 1'b0;
	assign rise     = s_sck & ~sck_d_reg;
	assign fall     = ~s_sck & sck_d_reg;
	assign cs_fall  = ~s_cs_n & cs_d_reg;
	assign hw_reset = pin_low && (rcnt_reg >= RST_CNT_W'(RP_CYC - 1));
	assign instr_new = {instr_reg[INSTR_BITS-2:0], s_lanes[LANE_INSTR_A]};
	assign addr_new  = {addr_reg[ADDR_W-NIB_W-1:0], s_lanes[NIB_W-1:0]};

	// ----------------------------------------------------------------
	// next-state logic
	// ----------------------------------------------------------------
	always_comb
	begin
		state_next  = state_reg;
		sck_d_next  = s_sck;
		cs_d_next   = s_cs_n;
		cnt_next    = cnt_reg;
		addr_next   = addr_reg;
		idx_next    = idx_reg;
		fill_next   = fill_reg;
		rcnt_next   = rcnt_reg;
		pu_next     = pu_reg;
		lanes_next  = lanes_reg;
		oe_next     = oe_reg;
		instr_next  = instr_reg;
		ivalid_next = 1'b0;
		merr_next   = merr_reg;
		ready_next  = ready_reg;
		cfg_next    = cfg_reg;
		sts_next    = sts_reg;
		bank_next   = bank_reg;
		prd_next    = pbuf[i_pbuf_raddr];
		pb_we       = 1'b0;
		pb_wa       = idx_reg;
		pb_wd       = s_lanes;

		// low-time counter, saturating
		if (!pin_low)
			rcnt_next = '0;
		else if (!hw_reset)
			rcnt_next = rcnt_reg + RST_CNT_W'(1);

		if (pin_low)
		begin
			// nothing on the bus is looked at while reset is low
			oe_next = LANES_OFF;
			if (hw_reset)
			begin
				state_next = ST_INIT;
				cfg_next   = CFG_VOL_RST;
				sts_next   = STS_VOL_RST;
				bank_next  = BANK_RST;
				fill_next  = '0;
				pu_next    = '0;
				ready_next = 1'b0;
			end
		end
		else if (state_reg == ST_INIT)
		begin
			// same init as power-up: fill buffer while waiting out init time, ready once both are done
			oe_next = LANES_OFF;
			if (fill_reg != (PB_AW+1)'(PAGE_BYTES))
			begin
				pb_we     = 1'b1;
				pb_wa     = fill_reg[PB_AW-1:0];
				pb_wd     = PBUF_FILL;
				fill_next = fill_reg + (PB_AW+1)'(1);
			end
			if (pu_reg != PU_CNT_W'(PU_CYC))
				pu_next = pu_reg + PU_CNT_W'(1);
			else if (fill_reg == (PB_AW+1)'(PAGE_BYTES))
			begin
				state_next = ST_IDLE;
				ready_next = 1'b1;
			end
		end
		else if (s_cs_n)
		begin
			// deselected: release lanes, drop any command
			oe_next    = LANES_OFF;
			state_next = ST_IDLE;
			if (i_cfg_we)
				cfg_next = i_cfg_wdata;
			if (i_sts_we)
				sts_next = i_sts_wdata;
			if (i_bank_we)
				bank_next = i_bank_wdata;
		end
		else
		begin
			case (state_reg)
				ST_IDLE:
				begin
					// a select fall is needed before any command
					if (cs_fall)
					begin
						state_next = ST_INSTR;
						cnt_next   = '0;
						merr_next  = 1'b0;
					end
				end
				ST_INSTR:
				begin
					if (rise)
					begin
						// instruction rides lane 0 of each quad unit
						instr_next = instr_new;
						if (s_lanes[LANE_INSTR_A] != s_lanes[LANE_INSTR_B])
							merr_next = 1'b1;
						cnt_next = cnt_reg + CNT_W'(1);
						if (cnt_reg == CNT_W'(INSTR_BITS - 1))
						begin
							ivalid_next = 1'b1;
							cnt_next    = '0;
							if (instr_new == OP_READ || instr_new == OP_WRITE)
								state_next = ST_ADDR;
							else
								state_next = ST_IGNORE;
						end
					end
				end
				ST_ADDR:
				begin
					if (rise)
					begin
						// nibble on the low quad, mirrored on the high quad
						addr_next = addr_new;
						if (s_lanes[LANES-1:NIB_W] != s_lanes[NIB_W-1:0])
							merr_next = 1'b1;
						cnt_next = cnt_reg + CNT_W'(1);
						if (cnt_reg == CNT_W'(ADDR_NIBBLES - 1))
						begin
							cnt_next = '0;
							idx_next = addr_new[PB_AW-1:0];
							if (instr_reg == OP_WRITE)
								state_next = ST_WDATA;
							else if (DUMMY_CYCLES == 0)
								state_next = ST_RDATA;
							else
								state_next = ST_DUMMY;
						end
					end
				end
				ST_DUMMY:
				begin
					if (rise)
					begin
						cnt_next = cnt_reg + CNT_W'(1);
						if (cnt_reg == CNT_W'(DUMMY_CYCLES - 1))
							state_next = ST_RDATA;
					end
				end
				ST_RDATA:
				begin
					// one byte across all lanes per falling edge
					if (fall)
					begin
						lanes_next = pbuf[idx_reg];
						oe_next    = LANES_ON;
						idx_next   = idx_reg + PB_AW'(1);
					end
				end
				ST_WDATA:
				begin
					// one byte across all lanes per rising edge
					if (rise)
					begin
						pb_we    = 1'b1;
						idx_next = idx_reg + PB_AW'(1);
					end
				end
				ST_IGNORE:
				begin
					oe_next = LANES_OFF;
				end
				default:
				begin
					state_next = ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			state_reg  <= ST_INIT;
			sck_d_reg  <= 1'b0;
			cs_d_reg   <= 1'b1;
			cnt_reg    <= '0;
			addr_reg   <= '0;
			idx_reg    <= '0;
			fill_reg   <= '0;
			rcnt_reg   <= '0;
			pu_reg     <= '0;
			lanes_reg  <= LANES_OFF;
			oe_reg     <= LANES_OFF;
			instr_reg  <= '0;
			ivalid_reg <= 1'b0;
			merr_reg   <= 1'b0;
			ready_reg  <= 1'b0;
			cfg_reg    <= CFG_VOL_RST;
			sts_reg    <= STS_VOL_RST;
			bank_reg   <= BANK_RST;
			prd_reg    <= '0;
		end
		else if (i_ce)
		begin
			state_reg  <= state_next;
			sck_d_reg  <= sck_d_next;
			cs_d_reg   <= cs_d_next;
			cnt_reg    <= cnt_next;
			addr_reg   <= addr_next;
			idx_reg    <= idx_next;
			fill_reg   <= fill_next;
			rcnt_reg   <= rcnt_next;
			pu_reg     <= pu_next;
			lanes_reg  <= lanes_next;
			oe_reg     <= oe_next;
			instr_reg  <= instr_next;
			ivalid_reg <= ivalid_next;
			merr_reg   <= merr_next;
			ready_reg  <= ready_next;
			cfg_reg    <= cfg_next;
			sts_reg    <= sts_next;
			bank_reg   <= bank_next;
			prd_reg    <= prd_next;
		end
	end

	// page buffer storage, one location per write
	always_ff @(posedge i_clk)
	begin
		if (i_ce && pb_we)
			pbuf[pb_wa] <= pb_wd;
	end

	// outputs straight from flops
	assign o_bidir_lanes    = lanes_reg;
	assign o_bidir_lanes_oe = oe_reg;
	assign o_pbuf_rdata     = prd_reg;
	assign o_cfg_vol        = cfg_reg;
	assign o_sts_vol        = sts_reg;
	assign o_bank           = bank_reg;
	assign o_instr          = instr_reg;
	assign o_instr_valid    = ivalid_reg;
	assign o_mirror_err     = merr_reg;
	assign o_ready          = ready_reg;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_reset_tristate: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && hw_reset |=> oe_reg == LANES_OFF && state_reg == ST_INIT)
		else $error("long reset did not tristate and abort");
	a_reset_regs: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && hw_reset |=> cfg_reg == CFG_VOL_RST && sts_reg == STS_VOL_RST && !ready_reg)
		else $error("volatile bits not restored");
	a_bank_clear: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && hw_reset ##1 i_ce && pin_low |=> bank_reg == BANK_RST)
		else $error("bank register not cleared");
	a_fill_ones: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && pb_we && state_reg == ST_INIT |=> pbuf[$past(pb_wa)] == PBUF_FILL)
		else $error("buffer not filled with ones");
	a_ready_wait: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(ready_reg) |-> pu_reg == PU_CNT_W'(PU_CYC) && state_reg == ST_IDLE)
		else $error("ready before init time");
	a_cs_tristate: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && s_cs_n ##1 i_ce && s_cs_n |=> oe_reg == LANES_OFF && state_reg != ST_INSTR)
		else $error("lanes driven while deselected");
	a_hold_ignore: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && pin_low && state_reg == ST_IDLE |=> state_reg inside {ST_IDLE, ST_INIT})
		else $error("command started during reset");
	a_instr_lane: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && !pin_low && !s_cs_n && state_reg == ST_INSTR && rise
		|=> instr_reg[0] == $past(s_lanes[LANE_INSTR_A]))
		else $error("instruction bit not from lane 0");
	a_addr_nibble: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && !pin_low && !s_cs_n && state_reg == ST_ADDR && rise
		|=> addr_reg[NIB_W-1:0] == $past(s_lanes[NIB_W-1:0]))
		else $error("address nibble not captured");
	a_byte_write: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && !pin_low && !s_cs_n && state_reg == ST_WDATA && rise
		|=> pbuf[$past(idx_reg)] == $past(s_lanes) ##1 1'b1)
		else $error("write byte not stored");
	a_read_drive: assert property (@(posedge i_clk) disable iff (i_rst)
		i_ce && !pin_low && !s_cs_n && state_reg == ST_RDATA && fall
		|=> oe_reg == LANES_ON && lanes_reg == pbuf[$past(idx_reg)])
		else $error("read byte not driven after fall");

	c_write: cover property (@(posedge i_clk) disable iff (i_rst)
		state_reg == ST_WDATA && rise);
	c_read: cover property (@(posedge i_clk) disable iff (i_rst)
		state_reg == ST_RDATA && fall);
	c_hw_reset: cover property (@(posedge i_clk) disable iff (i_rst)
		hw_reset && state_reg == ST_RDATA);
	c_mirror: cover property (@(posedge i_clk) disable iff (i_rst) $rose(merr_reg));

endmodule : dqs_lanes_reset

// [verification/dqs_host_model.sv]
// behavioural dual-quad host driving select, serial clock and eight lanes
`timescale 1ns/1ps
module dqs_host_model (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_bidir_lanes,
	output logic            o_sck,
	output logic            o_cs_n,
	output logic [7:0]      o_bidir_lanes
);
	logic       bad_mirror;
	logic [7:0] rd_bytes [0:7];

	// mode 0 idle: clock low, select high
	initial
	begin
		o_sck = 1'b0;
		o_cs_n = 1'b1;
		o_bidir_lanes = 8'h00;
		bad_mirror = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge i_clk);
	endtask : cyc

	// one lane value around one 80 ns clock, taken at the rise
	task automatic step(input logic [7:0] v);
		o_bidir_lanes <= v;
		cyc(4);
		o_sck <= 1'b1;
		cyc(4);
		o_sck <= 1'b0;
	endtask : step

	// whole command: instruction, address, then n bytes
	task automatic frame(input logic [7:0] op, input logic [31:0] addr, input int n,
		input bit wr, input logic [7:0] first);
		logic b;
		o_cs_n <= 1'b0;
		cyc(4);
		for (int i = 7; i >= 0; i--)
		begin
			b = op[i];
			step({i[0], ~i[0], i[0], b ^ bad_mirror, ~i[0], i[0], ~i[0], b});
		end
		for (int k = 7; k >= 0; k--)
			step({addr[4*k +: 4], addr[4*k +: 4]});
		for (int j = 0; j < n; j++)
		begin
			if (wr)
				step(8'(first + j));
			else
			begin
				// lanes released: show the inverse, never the old value
				o_bidir_lanes <= ~o_bidir_lanes;
				cyc(4);
				o_sck <= 1'b1;
				cyc(3);
				rd_bytes[j] = i_bidir_lanes;
				cyc(1);
				o_sck <= 1'b0;
			end
		end
		cyc(4);
		o_cs_n <= 1'b1;
		o_bidir_lanes <= ~o_bidir_lanes;
		cyc(8);
	endtask : frame
endmodule : dqs_host_model

// [verification/tb_top.sv]
// self-checking bench for the dual-quad lane front end and its reset
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
	begin \
		n_compared++; \
		if ((got) !== (ex)) \
		begin \
			err_total++; \
			$display("MISMATCH %s exp %h got %h", nm, ex, got); \
		end \
	end
module tb_top;
	import dqs_pkg::*;
	localparam logic [7:0] OP_RD = 8'hA5;
	localparam logic [7:0] OP_WR = 8'h5A;
	logic       clk = 0, rst = 1, reset_n = 1;
	logic       cfg_we = 0, sts_we = 0, bank_we = 0;
	logic [7:0] cfg_wd = 0, sts_wd = 0, bank_wd = 0;
	logic [3:0] raddr = 0;
	logic       sck, cs_n, iv, merr, ready;
	logic [7:0] h_o, d_o, d_oe, pb, cfg, sts, bank, instr, last_op;
	wire  [7:0] lanes = (d_oe & d_o) | (~d_oe & h_o);
	int         err_total = 0, n_compared = 0, n_valid = 0;
	logic [7:0] cfg_np;
	logic       ready_np;

	always #5 clk = ~clk;

	dqs_host_model u_host (.i_clk(clk), .i_bidir_lanes(lanes), .o_sck(sck), .o_cs_n(cs_n),
		.o_bidir_lanes(h_o));

	dqs_lanes_reset #(.PAGE_BYTES(16), .PU_CYC(50), .OP_READ(OP_RD), .OP_WRITE(OP_WR)) i_dut (
		.i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_sck(sck), .i_cs_n(cs_n),
		.i_reset_n(reset_n), .i_bidir_lanes(lanes), .o_bidir_lanes(d_o),
		.o_bidir_lanes_oe(d_oe), .i_cfg_we(cfg_we), .i_cfg_wdata(cfg_wd),
		.i_sts_we(sts_we), .i_sts_wdata(sts_wd), .i_bank_we(bank_we),
		.i_bank_wdata(bank_wd), .i_pbuf_raddr(raddr), .o_pbuf_rdata(pb), .o_cfg_vol(cfg),
		.o_sts_vol(sts), .o_bank(bank), .o_instr(instr), .o_instr_valid(iv),
		.o_mirror_err(merr), .o_ready(ready));

	// twin without a reset pin, fed the same pins
	dqs_lanes_reset #(.PAGE_BYTES(16), .PU_CYC(50), .HAS_RESET_PIN(1'b0), .OP_READ(OP_RD),
		.OP_WRITE(OP_WR)) i_dut_np (
		.i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_sck(sck), .i_cs_n(cs_n),
		.i_reset_n(reset_n), .i_bidir_lanes(lanes), .o_bidir_lanes(),
		.o_bidir_lanes_oe(), .i_cfg_we(cfg_we), .i_cfg_wdata(cfg_wd),
		.i_sts_we(sts_we), .i_sts_wdata(sts_wd), .i_bank_we(bank_we),
		.i_bank_wdata(bank_wd), .i_pbuf_raddr(raddr), .o_pbuf_rdata(), .o_cfg_vol(cfg_np),
		.o_sts_vol(), .o_bank(), .o_instr(), .o_instr_valid(),
		.o_mirror_err(), .o_ready(ready_np));

	// record each completed instruction
	always @(posedge clk)
		if (iv === 1'b1)
		begin
			last_op <= instr;
			n_valid <= n_valid + 1;
		end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task automatic peek(input logic [3:0] a, input logic [7:0] ex);
		raddr <= a;
		cyc(2);
		`CHK("pbuf", ex, pb)
	endtask : peek

	// init done within bound, then whole buffer holds ones
	task automatic wait_ready_ones;
		for (int i = 0; i < 200 && ready !== 1'b1; i++)
			cyc(1);
		`CHK("ready", 1'b1, ready)
		for (int a = 0; a < 16; a++)
			peek(4'(a), 8'hFF);
	endtask : wait_ready_ones

	task automatic t_reset_vals;
		`CHK("cfg", 8'h00, cfg)
		`CHK("bank", 8'h00, bank)
		`CHK("oe", 8'h00, d_oe)
		`CHK("ready", 1'b0, ready)
		wait_ready_ones();
	endtask : t_reset_vals

	// write four bytes wrapping the buffer end, read them back
	task automatic t_write_read;
		int v0;
		v0 = n_valid;
		u_host.frame(OP_WR, 32'h0000_000E, 4, 1, 8'hA0);
		`CHK("op", OP_WR, last_op)
		`CHK("n_valid", v0 + 1, n_valid)
		for (int j = 0; j < 4; j++)
			peek(4'(14 + j), 8'(8'hA0 + j));
		u_host.frame(OP_RD, 32'h1234_567E, 4, 0, 8'h00);
		for (int j = 0; j < 4; j++)
			`CHK("rd", 8'(8'hA0 + j), u_host.rd_bytes[j])
		`CHK("oe", 8'h00, d_oe)
		`CHK("mirror", 1'b0, merr)
	endtask : t_write_read

	// broken lane copy on an unknown instruction: flagged, data ignored
	task automatic t_mirror;
		u_host.bad_mirror = 1'b1;
		u_host.frame(8'h3C, 32'h0000_000E, 2, 1, 8'h11);
		u_host.bad_mirror = 1'b0;
		`CHK("mirror", 1'b1, merr)
		`CHK("op", 8'h3C, last_op)
		peek(4'hE, 8'hA0);
		u_host.frame(OP_WR, 32'h0, 0, 1, 8'h00);
		`CHK("mirror", 1'b0, merr)
	endtask : t_mirror

	task automatic t_hw_reset;
		int v1;
		cfg_we <= 1;
		sts_we <= 1;
		bank_we <= 1;
		cfg_wd <= 8'h3C;
		sts_wd <= 8'hC3;
		bank_wd <= 8'h5A;
		cyc(1);
		cfg_we <= 0;
		sts_we <= 0;
		bank_we <= 0;
		cyc(2);
		`CHK("sts", 8'hC3, sts)
		`CHK("bank", 8'h5A, bank)
		// a pulse shorter than the minimum keeps everything
		reset_n <= 0;
		cyc(10);
		reset_n <= 1;
		cyc(8);
		`CHK("cfg", 8'h3C, cfg)
		`CHK("ready", 1'b1, ready)
		// long pulse cuts a read short; a later frame is ignored
		fork
			begin
				u_host.frame(OP_RD, 32'hE, 4, 0, 8'h00);
				u_host.frame(OP_WR, 32'h0, 0, 1, 8'h00);
			end
			begin
				cyc(150);
				reset_n <= 0;
				cyc(3);
				v1 = n_valid;
				cyc(357);
				`CHK("oe", 8'h00, d_oe)
				`CHK("n_valid", v1, n_valid)
				`CHK("cfg", 8'h00, cfg)
				`CHK("sts", 8'h00, sts)
				`CHK("bank", 8'h00, bank)
				`CHK("cfg_np", 8'h3C, cfg_np)
				`CHK("ready_np", 1'b1, ready_np)
				reset_n <= 1;
			end
		join
		cyc(30);
		`CHK("ready", 1'b0, ready)
		wait_ready_ones();
	endtask : t_hw_reset

	// watchdog well beyond the roughly 1700 cycles of the run
	initial
	begin
		cyc(20000);
		err_total++;
		end_sim();
	end

	initial
	begin
		cyc(5);
		rst <= 0;
		t_reset_vals();
		t_write_read();
		t_mirror();
		t_hw_reset();
		t_write_read();
		end_sim();
	end
endmodule : tb_top
